// file: verilog/rfc_pkg.sv
// Constants, register map and carrier types for the RTC flag and clock-output block
package rfc_pkg;
	localparam logic [7:0] ADDR_EXT = 8'h1D;
	localparam logic [7:0] ADDR_FLAG = 8'h1E;
	localparam logic [7:0] ADDR_CTRL = 8'h1F;
	localparam logic [7:0] ADDR_PINCTL = 8'h32;

	localparam int EXT_FSEL_HI = 7;
	localparam int EXT_FSEL_LO = 6;
	localparam int EXT_UPDATE_PERIOD_SELECT = 5;
	localparam int FLAG_UF = 5;
	localparam int FLAG_VLF = 1;
	localparam int CTRL_STOP = 6;
	localparam int CTRL_UIE = 5;
	localparam int PIN_ONE_HZ_PULSE_ENABLE = 4;
	localparam int PIN_SEL_HI = 1;
	localparam int PIN_SEL_LO = 0;

	localparam logic [7:0] EXT_RST = 8'h00;
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [7:0] PINCTL_RST = 8'h00;
	localparam logic [7:0] PINCTL_MASK = 8'h17;
	localparam logic VLF_RST = 1'b1;

	localparam logic [1:0] FSEL_OFF = 2'h0;
	localparam logic [1:0] FSEL_1HZ = 2'h1;
	localparam logic [1:0] FSEL_1024 = 2'h2;
	localparam logic [1:0] FSEL_32K = 2'h3;
	localparam logic [1:0] PSEL_IRQ_B = 2'h0;
	localparam logic [1:0] PSEL_IRQ_A = 2'h1;

	localparam int CLK_PERIOD_NS = 25;
	localparam int UPD_RELEASE_NS = 7813000;
	localparam int UPD_RELEASE_CYC = UPD_RELEASE_NS / CLK_PERIOD_NS;
	localparam int OSC_HZ = 32768;
	localparam int PULSE_HIZ_US = 31250;
	localparam int DIV_W = 15;
	localparam logic [DIV_W-1:0] PULSE_HIZ_TICKS = DIV_W'((PULSE_HIZ_US * OSC_HZ + 999999) / 1000000);
	localparam int DIV_1024_BIT = 4;
	localparam int DIV_1HZ_BIT = 14;
	localparam logic [5:0] SEC_PER_MIN = 6'h3C;

	typedef struct packed {
		logic out;
		logic oe;
	} rfc_pin_s;

	typedef struct packed {
		logic rd;
		logic wr;
		logic [7:0] addr;
		logic [7:0] wdata;
	} rfc_reg_req_s;

	typedef enum logic [1:0] {
		UPD_IDLE = 2'b01,
		UPD_LOW = 2'b10
	} rfc_upd_e;
endpackage

// file: verilog/rfc_sync2.sv
// Two-stage synchroniser for asynchronous pin levels
module rfc_sync2 #(
	parameter int WIDTH = 1
) (
	input wire logic i_clk_sys,
	input wire logic i_nrst,
	input wire logic [WIDTH-1:0] i_async,
	output logic [WIDTH-1:0] o_sync
);
	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] sync_q;

	if (WIDTH < 1) begin : g_chk
		$error("rfc_sync2 needs WIDTH of at least 1");
	end

	always_ff @(posedge i_clk_sys) begin
		if (!i_nrst) begin
			meta_q <= '0;
			sync_q <= '0;
		end else begin
			meta_q <= i_async;
			sync_q <= meta_q;
		end
	end

	assign o_sync = sync_q;
endmodule

// file: verilog/rfc_prescaler.sv
// Oscillator tick divider with second and minute update events
module rfc_prescaler
	import rfc_pkg::*;
(
	input wire logic i_clk_sys,
	input wire logic i_nrst,
	input wire logic i_osc_tick,
	input wire logic i_minute_sel,
	output logic [rfc_pkg::DIV_W-1:0] o_div,
	output logic o_update_evt
);
	logic [DIV_W-1:0] div_q;
	logic [5:0] sec_q;
	logic evt_q;
	wire sec_wrap = i_osc_tick && (div_q == {DIV_W{1'b1}});
	wire min_wrap = sec_wrap && (sec_q == SEC_PER_MIN - 6'h1);

	always_ff @(posedge i_clk_sys) begin
		if (!i_nrst) begin
			div_q <= '0;
			sec_q <= '0;
			evt_q <= 1'b0;
		end else begin
			if (i_osc_tick)
				div_q <= div_q + DIV_W'(1);
			if (min_wrap)
				sec_q <= '0;
			else if (sec_wrap)
				sec_q <= sec_q + 6'h1;
			evt_q <= i_minute_sel ? min_wrap : sec_wrap;
		end
	end

	assign o_div = div_q;
	assign o_update_evt = evt_q;
endmodule

// file: verilog/rfc_flags_clkout.sv
// Update and voltage-low flags, interrupt pin and clock output routing
module rfc_flags_clkout #(
	parameter int RELEASE_CYC = rfc_pkg::UPD_RELEASE_CYC
) (
	input wire logic i_clk_sys,
	input wire logic i_nrst,
	input wire rfc_pkg::rfc_reg_req_s i_reg_req,
	output logic [7:0] o_reg_rdata,
	input wire logic i_osc_32k,
	input wire logic i_data_loss,
	input wire logic i_chip_sel_clkout_en_pin,
	input wire logic i_interface_select_pin,
	input wire logic i_backup_mode,
	output rfc_pkg::rfc_pin_s o_interrupt_pin_a,
	output rfc_pkg::rfc_pin_s o_interrupt_pin_b,
	output rfc_pkg::rfc_pin_s o_data_out_clock_pin
);
	import rfc_pkg::*;

	if (RELEASE_CYC < 1 || RELEASE_CYC >= (1 << 20)) begin : g_chk
		$error("RELEASE_CYC must lie between 1 and 2**20-1");
	end

	logic [3:0] pin_s;
	logic osc_d_q;
	logic loss_d_q;
	logic [DIV_W-1:0] div;
	logic upd_tick;

	logic [7:0] ext_q;
	logic [7:0] ctrl_q;
	logic [7:0] pinctl_q;
	logic uf_q;
	logic vlf_q;
	logic [7:0] rdata_q;
	rfc_upd_e state_q;
	rfc_upd_e state_d;
	logic [19:0] cnt_q;
	logic [19:0] cnt_d;
	rfc_pin_s irq_a_q;
	rfc_pin_s irq_b_q;
	rfc_pin_s do_q;

	// Pins come from outside the clock domain
	rfc_sync2 #(
		.WIDTH(4)
	) u_sync (
		.i_clk_sys(i_clk_sys),
		.i_nrst(i_nrst),
		.i_async({i_osc_32k, i_data_loss, i_chip_sel_clkout_en_pin, i_interface_select_pin}),
		.o_sync(pin_s)
	);

	wire osc_lvl = pin_s[3];
	wire loss_lvl = pin_s[2];
	wire ce_pin = pin_s[1];
	wire spi_mode = pin_s[0];
	wire osc_edge = osc_lvl && !osc_d_q;
	wire loss_rise = loss_lvl && !loss_d_q;

	rfc_prescaler u_div (
		.i_clk_sys(i_clk_sys),
		.i_nrst(i_nrst),
		.i_osc_tick(osc_edge),
		.i_minute_sel(ext_q[EXT_UPDATE_PERIOD_SELECT]),
		.o_div(div),
		.o_update_evt(upd_tick)
	);

	// Register decode
	wire wr_ext = i_reg_req.wr && (i_reg_req.addr == ADDR_EXT);
	wire wr_flag = i_reg_req.wr && (i_reg_req.addr == ADDR_FLAG);
	wire wr_ctrl = i_reg_req.wr && (i_reg_req.addr == ADDR_CTRL);
	wire wr_pinctl = i_reg_req.wr && (i_reg_req.addr == ADDR_PINCTL);

	wire clk_stop = ctrl_q[CTRL_STOP];
	wire update_irq_enable = ctrl_q[CTRL_UIE];
	wire [1:0] fsel = {ext_q[EXT_FSEL_HI], ext_q[EXT_FSEL_LO]};
	wire [1:0] psel = {pinctl_q[PIN_SEL_HI], pinctl_q[PIN_SEL_LO]};

	wire upd_evt = upd_tick && !clk_stop;
	// Writing 1 leaves the flags alone; a same-cycle event beats the clear
	wire uf_clr = wr_flag && !i_reg_req.wdata[FLAG_UF];
	wire vlf_clr = wr_flag && !i_reg_req.wdata[FLAG_VLF];
	wire uf_d = upd_evt || (uf_q && !uf_clr);
	wire vlf_d = loss_rise || (vlf_q && !vlf_clr);

	// Interrupt hold state for update events
	always_comb begin
		state_d = state_q;
		cnt_d = cnt_q;
		case (state_q)
			UPD_IDLE: begin
				if (upd_evt && update_irq_enable) begin
					state_d = UPD_LOW;
					cnt_d = 20'(RELEASE_CYC - 1);
				end
			end
			UPD_LOW: begin
				if (upd_evt && update_irq_enable) begin
					cnt_d = 20'(RELEASE_CYC - 1);
				end else if (cnt_q == 20'h0 || !update_irq_enable || uf_clr) begin
					state_d = UPD_IDLE;
				end else begin
					cnt_d = cnt_q - 20'h1;
				end
			end
			default: begin
				state_d = UPD_IDLE;
				cnt_d = 20'h0;
			end
		endcase
	end

	// Low for the rest of the second after the high-impedance phase
	wire pulse_low = pinctl_q[PIN_ONE_HZ_PULSE_ENABLE] && (div >= PULSE_HIZ_TICKS);

	// Clock source; 32768 Hz survives the stop bit, the divided ones do not
	wire force32 = ce_pin && !spi_mode && (fsel == FSEL_OFF);
	logic clk_on;
	logic clk_wave;
	always_comb begin
		clk_on = 1'b0;
		clk_wave = 1'b1;
		case (fsel)
			FSEL_1HZ: begin
				clk_on = !clk_stop;
				clk_wave = div[DIV_1HZ_BIT];
			end
			FSEL_1024: begin
				clk_on = !clk_stop;
				clk_wave = div[DIV_1024_BIT];
			end
			FSEL_32K: begin
				clk_on = 1'b1;
				clk_wave = osc_lvl;
			end
			default: begin
				clk_on = force32;
				clk_wave = osc_lvl;
			end
		endcase
	end

	// Destination pin; backup cuts the second irq pin and the data pin
	wire sel_a = !force32 && clk_on && (psel == PSEL_IRQ_A);
	wire sel_b = !force32 && clk_on && (psel == PSEL_IRQ_B) && !i_backup_mode;
	wire sel_do = (force32 || (clk_on && psel[1] && !spi_mode)) && !i_backup_mode;

	wire irq_a_low = (state_d == UPD_LOW) || pulse_low || (sel_a && !clk_wave);
	wire irq_b_low = sel_b && !clk_wave;

	logic [7:0] rdata_d;
	always_comb begin
		case (i_reg_req.addr)
			ADDR_EXT: rdata_d = ext_q;
			ADDR_FLAG: rdata_d = 8'(({7'h0, uf_q} << FLAG_UF) | ({7'h0, vlf_q} << FLAG_VLF));
			ADDR_CTRL: rdata_d = ctrl_q;
			ADDR_PINCTL: rdata_d = pinctl_q;
			default: rdata_d = 8'h00;
		endcase
	end

	always_ff @(posedge i_clk_sys) begin
		if (!i_nrst) begin
			osc_d_q <= 1'b0;
			loss_d_q <= 1'b0;
			ext_q <= EXT_RST;
			ctrl_q <= CTRL_RST;
			pinctl_q <= PINCTL_RST;
			uf_q <= 1'b0;
			vlf_q <= VLF_RST;
			state_q <= UPD_IDLE;
			cnt_q <= 20'h0;
			rdata_q <= 8'h00;
		end else begin
			osc_d_q <= osc_lvl;
			loss_d_q <= loss_lvl;
			if (wr_ext)
				ext_q <= i_reg_req.wdata;
			if (wr_ctrl)
				ctrl_q <= i_reg_req.wdata;
			if (wr_pinctl)
				pinctl_q <= i_reg_req.wdata & PINCTL_MASK;
			uf_q <= uf_d;
			vlf_q <= vlf_d;
			state_q <= state_d;
			cnt_q <= cnt_d;
			if (i_reg_req.rd)
				rdata_q <= rdata_d;
		end
	end

	// Open-drain pins drive low only while enabled
	always_ff @(posedge i_clk_sys) begin
		if (!i_nrst) begin
			irq_a_q <= '{out: 1'b0, oe: 1'b0};
			irq_b_q <= '{out: 1'b0, oe: 1'b0};
			do_q <= '{out: 1'b0, oe: 1'b0};
		end else begin
			irq_a_q <= '{out: 1'b0, oe: irq_a_low};
			irq_b_q <= '{out: 1'b0, oe: irq_b_low};
			// Undriven data pin shows 0, so a stopped output leaves no stray wave
			do_q <= '{out: clk_wave && sel_do, oe: sel_do};
		end
	end

	assign o_reg_rdata = rdata_q;
	assign o_interrupt_pin_a = irq_a_q;
	assign o_interrupt_pin_b = irq_b_q;
	assign o_data_out_clock_pin = do_q;
endmodule

// file: testbench/rfc_flags_clkout_assertions.sv
// Port checker for the flag and clock-output block
module rfc_flags_clkout_checker
	import rfc_pkg::*;
#(
	parameter int RELEASE_CYC = rfc_pkg::UPD_RELEASE_CYC
) (
	input wire logic i_clk_sys,
	input wire logic i_nrst,
	input wire rfc_pkg::rfc_reg_req_s i_reg_req,
	input wire logic [7:0] o_reg_rdata,
	input wire logic i_osc_32k,
	input wire logic i_data_loss,
	input wire logic i_chip_sel_clkout_en_pin,
	input wire logic i_interface_select_pin,
	input wire logic i_backup_mode,
	input wire rfc_pkg::rfc_pin_s o_interrupt_pin_a,
	input wire rfc_pkg::rfc_pin_s o_interrupt_pin_b,
	input wire rfc_pkg::rfc_pin_s o_data_out_clock_pin
);
	default clocking cb @(posedge i_clk_sys);
	endclocking
	default disable iff (!i_nrst);
	wire logic rd_flag = i_reg_req.rd && i_reg_req.addr == ADDR_FLAG;
	wire logic wr_flag = i_reg_req.wr && i_reg_req.addr == ADDR_FLAG;
	wire logic wr_ctrl = i_reg_req.wr && i_reg_req.addr == ADDR_CTRL;
	wire logic rd_ctrl = i_reg_req.rd && i_reg_req.addr == ADDR_CTRL;
	drain_only_a: assert property (o_interrupt_pin_a.out == 1'h0) else $error("pin a out high");
	backup_pin_b_a: assert property (i_backup_mode |=> !o_interrupt_pin_b.oe) else $error("pin b in backup");
	backup_data_a: assert property (i_backup_mode |=> !o_data_out_clock_pin.oe) else $error("data pin in backup");
	reset_idle_a: assert property (disable iff (1'h0) !i_nrst |=> !o_interrupt_pin_a.oe && !o_interrupt_pin_b.oe
		&& !o_data_out_clock_pin.oe) else $error("pin driven in reset");
	flag_zeros_a: assert property (rd_flag |=> (o_reg_rdata & 8'hDD) == 8'h00) else $error("flag bits");
	pinctl_zeros_a: assert property (i_reg_req.rd && i_reg_req.addr == ADDR_PINCTL |=>
		(o_reg_rdata & 8'hE8) == 8'h00) else $error("pin control bits");
	low_clear_a: assert property ((!i_data_loss)[*4] ##0 (wr_flag && !i_reg_req.wdata[FLAG_VLF]) ##2 rd_flag
		|=> !o_reg_rdata[FLAG_VLF]) else $error("low flag kept");
	ctrl_back_a: assert property (wr_ctrl ##2 rd_ctrl |=> o_reg_rdata == $past(i_reg_req.wdata, 3))
		else $error("control readback");
endmodule
bind rfc_flags_clkout rfc_flags_clkout_checker #(.RELEASE_CYC(RELEASE_CYC)) rfc_flags_clkout_checker_inst (
	.i_clk_sys, .i_nrst, .i_reg_req, .o_reg_rdata, .i_osc_32k, .i_data_loss, .i_chip_sel_clkout_en_pin,
	.i_interface_select_pin, .i_backup_mode, .o_interrupt_pin_a, .o_interrupt_pin_b, .o_data_out_clock_pin);

// file: testbench/rfc_host_model.sv
// Host processor model on the register port
module rfc_host_model (
	input wire logic i_clk_sys,
	output rfc_pkg::rfc_reg_req_s o_req,
	input wire logic [7:0] i_rdata
);
	timeunit 1ns;
	timeprecision 100ps;
	import rfc_pkg::*;
	initial o_req = '0;
	task automatic acc(input logic r, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
		@(posedge i_clk_sys);
		#1 o_req = '{rd: r, wr: !r, addr: a, wdata: d};
		@(posedge i_clk_sys);
		#1 o_req = '0;
		q = i_rdata;
	endtask
	// Contents untrusted after power-on or a low-voltage flag
	task automatic init();
		logic [7:0] q;
		acc(0, ADDR_EXT, 8'h00, q);
		acc(0, ADDR_CTRL, 8'h00, q);
		acc(0, ADDR_PINCTL, 8'h00, q);
		acc(0, ADDR_FLAG, 8'h00, q);
	endtask
endmodule

// file: testbench/rfc_flags_clkout_tb.sv
// Self-checking bench for the flag and clock-output block
module rfc_flags_clkout_tb;
	timeunit 1ns;
	timeprecision 100ps;
	import rfc_pkg::*;
	logic i_clk_sys = 0, i_nrst = 0, osc = 0, dl = 0, ce = 1, spi = 0, bk = 0;
	rfc_reg_req_s req;
	logic [7:0] rdata;
	rfc_pin_s pa, pb, pd;
	int failures = 0, n_compared = 0, t;
	logic [1:0] sel = 0;
	wire logic wave = sel == 2 ? pa.oe : sel == 1 ? pb.oe : pd.out;
	always #12.5 i_clk_sys = ~i_clk_sys;
	// Fast oscillator keeps a full second within the run
	always @(posedge i_clk_sys) osc <= #1 ~osc;
	rfc_flags_clkout #(.RELEASE_CYC(50)) rfc_flags_clkout_inst (.i_clk_sys, .i_nrst, .i_reg_req(req),
		.o_reg_rdata(rdata), .i_osc_32k(osc), .i_data_loss(dl), .i_chip_sel_clkout_en_pin(ce),
		.i_interface_select_pin(spi), .i_backup_mode(bk), .o_interrupt_pin_a(pa), .o_interrupt_pin_b(pb),
		.o_data_out_clock_pin(pd));
	rfc_host_model rfc_host_model_inst (.i_clk_sys, .o_req(req), .i_rdata(rdata));
	task automatic conclude();
		$display("compared %0d failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [7:0] s, input logic [7:0] e);
		n_compared++;
		if (s !== e) begin
			failures++;
			$display("[ERR] %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge i_clk_sys);
		#1;
	endtask
	task automatic w(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] q;
		rfc_host_model_inst.acc(0, a, d, q);
	endtask
	task automatic r(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] q;
		rfc_host_model_inst.acc(1, a, 8'h00, q);
		chk("rdata", q, e);
	endtask
	task automatic cnt(input logic [1:0] s, input int lo, input int hi);
		logic p;
		sel = s;
		cyc(4);
		p = wave;
		t = 0;
		repeat (256) begin
			cyc(1);
			t += (wave !== p);
			p = wave;
		end
		chk("toggles", lo <= t && t <= hi, 1'h1);
	endtask
	task automatic t_reset();
		cnt(0, 200, 256);
		ce = 0;
		r(ADDR_EXT, 8'h00);
		r(ADDR_CTRL, 8'h00);
		r(ADDR_PINCTL, 8'h00);
		r(ADDR_FLAG, 8'h02);
		w(ADDR_FLAG, 8'hFF);
		r(ADDR_FLAG, 8'h02);
		rfc_host_model_inst.init();
		r(ADDR_FLAG, 8'h00);
		dl = 1;
		cyc(6);
		r(ADDR_FLAG, 8'h02);
		dl = 0;
		w(ADDR_CTRL, 8'h20);
		r(ADDR_CTRL, 8'h20);
		r(8'h40, 8'h00);
		$display("register test end");
	endtask
	task automatic t_update();
		int k;
		k = 0;
		w(ADDR_FLAG, 8'h00);
		while (pa.oe !== 1'h1 && k < 70000) begin
			cyc(1);
			k++;
		end
		chk("irq a", pa.oe, 1'h1);
		if (k >= 70000) conclude();
		w(ADDR_FLAG, 8'h20);
		r(ADDR_FLAG, 8'h20);
		cyc(36);
		chk("irq a", pa.oe, 1'h1);
		cyc(16);
		chk("irq a", pa.oe, 1'h0);
		w(ADDR_FLAG, 8'h00);
		r(ADDR_FLAG, 8'h00);
		w(ADDR_PINCTL, 8'h10);
		chk("irq a", pa.oe, 1'h0);
		cyc(2100);
		chk("irq a", pa.oe, 1'h1);
		w(ADDR_PINCTL, 8'h00);
		cyc(2);
		chk("irq a", pa.oe, 1'h0);
		$display("update test end");
	endtask
	task automatic t_clkout();
		int lo[4] = '{0, 0, 6, 200};
		int hi[4] = '{0, 1, 10, 256};
		w(ADDR_PINCTL, 8'hFE);
		r(ADDR_PINCTL, 8'h16);
		for (int f = 0; f < 4; f++) begin
			w(ADDR_EXT, {f[1:0], 6'h00});
			cnt(0, lo[f], hi[f]);
		end
		w(ADDR_CTRL, 8'h40);
		w(ADDR_EXT, 8'h80);
		cnt(0, 0, 0);
		w(ADDR_EXT, 8'hC0);
		cnt(0, 200, 256);
		spi = 1;
		cyc(6);
		chk("data oe", pd.oe, 1'h0);
		spi = 0;
		w(ADDR_CTRL, 8'h00);
		w(ADDR_PINCTL, 8'h00);
		w(ADDR_EXT, 8'h80);
		cnt(1, 6, 10);
		chk("data oe", pd.oe, 1'h0);
		bk = 1;
		cnt(1, 0, 0);
		w(ADDR_PINCTL, 8'h01);
		cnt(2, 6, 10);
		bk = 0;
		$display("clock test end");
	endtask
	initial begin
		cyc(12);
		i_nrst = 1;
		t_reset();
		t_update();
		t_clkout();
		conclude();
	end
endmodule
